// File: core/power_mode_controller.sv
// Top of the power mode controller: APB registers, mode sequencer, power outputs
module power_mode_controller
    import pmc_pkg::*;
(
    input  wire  logic              clock,      // System clock, 100 MHz
    input  wire  logic              rst,        // Async reset, active high
    input  wire  logic              psel,       // APB select
    input  wire  logic              penable,    // APB access phase
    input  wire  logic              pwrite,     // APB direction
    input  wire  logic [7:0]        paddr,      // APB byte address
    input  wire  logic [31:0]       pwdata,     // APB write data
    output logic [31:0]             prdata,     // APB read data
    output logic                    pready,     // APB ready
    output logic                    pslverr,    // APB error on unmapped address
    input  wire  wake_t             wakeSrc,    // Wakeup sources
    input  wire  logic              resetWake,  // external_reset_pin or watchdog_reset seen
    output logic [TMPL_W-1:0]       subsysEn,   // Per-subsystem enables
    output logic                    cpuEn,      // Processor core enable
    output power_t                  power,      // Regulator and clock controls
    output logic [4:0]              modeNow,    // Current one-hot mode
    output logic                    irq         // Level interrupt
);
    mode_t             state;           // Global mode
    logic [TMPL_W-1:0] actTmpl;         // Active template
    logic [TMPL_W-1:0] altTmpl;         // Alternate template
    logic [1:0]        regCtrl;         // Regulator enables
    logic [WAKE_W-1:0] wakeEn;          // Wakeup enables
    logic [EVT_W-1:0]  irqStat;         // Sticky events
    logic [EVT_W-1:0]  irqMask;         // Event mask
    logic [EVT_W-1:0]  events;          // Event pulses this cycle
    logic              wake;            // Qualified wake
    logic              resumeDone;      // Settle finished
    logic              resumeStart;     // Settle begins
    logic              wrStrobe;        // APB write accepted
    logic              rdStrobe;        // APB read accepted
    logic              modeWrite;       // Mode request written
    logic [MODE_W-1:0] modeReq;         // Requested mode code
    logic              mapped;          // Address decodes
    logic              cpuForce;        // Core re-enabled in active mode by wake until template rewritten
    logic [31:0]       next_prdata;     // Read mux

    // APB access phase is one cycle: pready is high on every access
    assign wrStrobe  = psel & penable & pwrite;
    assign rdStrobe  = psel & penable & ~pwrite;
    assign modeWrite = wrStrobe && paddr == OFS_MODE_REQ;
    assign modeReq   = pwdata[MODE_W-1:0];

    // Address decode
    always_comb begin
        unique case (paddr)
            OFS_MODE_REQ, OFS_ACT_TMPL, OFS_ALT_TMPL, OFS_REG_CTRL,
            OFS_WAKE_EN, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Wake qualification per mode
    wake_filter u_wake (
        .clock   (clock),
        .rst     (rst),
        .sources (wakeSrc),
        .enables (wakeEn),
        .inSleep (state == ST_SLEEP),
        .inHib   (state == ST_HIB),
        .wake    (wake)
    );

    // Regulator settle timer for leaving sleep
    resume_timer u_resume (
        .clock (clock),
        .rst   (rst),
        .start (resumeStart),
        .done  (resumeDone)
    );

    // Hibernate wakes through the same settle path; its limit is looser
    assign resumeStart = (state == ST_SLEEP || state == ST_HIB) && (wake || resetWake);

    // Global mode sequencer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= ST_ACTIVE;
        end else begin
            unique case (state)
                ST_ACTIVE, ST_ALT: begin
                    if (modeWrite) begin
                        unique case (modeReq)
                            REQ_ACTIVE: state <= ST_ACTIVE;
                            REQ_ALT:    state <= ST_ALT;
                            REQ_SLEEP:  state <= ST_SLEEP;
                            REQ_HIB:    state <= ST_HIB;
                        endcase
                    end
                end
                ST_SLEEP, ST_HIB: begin
                    if (resumeStart) begin
                        state <= ST_RESUME;
                    end
                end
                ST_RESUME: begin
                    if (resumeDone) begin
                        state <= ST_ACTIVE;
                    end
                end
                default: state <= ST_ACTIVE;
            endcase
        end
    end

    // Event pulses for the status register
    always_comb begin
        events = '0;
        events[EV_SLEEP_IN] = modeWrite && modeReq == REQ_SLEEP &&
                              (state == ST_ACTIVE || state == ST_ALT);
        events[EV_HIB_IN]   = modeWrite && modeReq == REQ_HIB &&
                              (state == ST_ACTIVE || state == ST_ALT);
        events[EV_WAKE]     = resumeDone;
        events[EV_BAD_REQ]  = modeWrite && !(state == ST_ACTIVE || state == ST_ALT);
    end

    // Templates, regulator control, wake enables, mask
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            actTmpl <= ACT_TMPL_RST;
            altTmpl <= ALT_TMPL_RST;
            regCtrl <= REG_CTRL_RST;
            wakeEn  <= WAKE_EN_RST;
            irqMask <= '0;
        end else if (wrStrobe) begin
            unique case (paddr)
                OFS_ACT_TMPL: actTmpl <= pwdata[TMPL_W-1:0];
                OFS_ALT_TMPL: altTmpl <= pwdata[TMPL_W-1:0];
                OFS_REG_CTRL: regCtrl <= pwdata[1:0];
                OFS_WAKE_EN:  wakeEn  <= pwdata[WAKE_W-1:0];
                OFS_IRQ_MASK: irqMask <= pwdata[EVT_W-1:0];
                default: ;
            endcase
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irqStat <= '0;
        end else if (wrStrobe && paddr == OFS_IRQ_STAT) begin
            irqStat <= (irqStat & ~pwdata[EVT_W-1:0]) | events;
        end else begin
            irqStat <= irqStat | events;
        end
    end

    // Core forced on in active mode after a wake until firmware writes the active template
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cpuForce <= 1'b0;
        end else if (resumeDone) begin
            cpuForce <= 1'b1;
        end else if (wrStrobe && paddr == OFS_ACT_TMPL) begin
            cpuForce <= 1'b0;
        end
    end

    // Power outputs, all registered
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            subsysEn <= ACT_TMPL_RST;
            cpuEn    <= 1'b1;
            power    <= '{digReg: 1'b1, anaReg: 1'b1, buzz: 1'b0,
                          hibReg: 1'b1, lowClk: 1'b1, fastClk: 1'b1};
            modeNow  <= ST_ACTIVE;
        end else begin
            modeNow <= state;
            unique case (state)
                ST_ACTIVE: begin
                    subsysEn <= actTmpl;
                    cpuEn    <= actTmpl[TMPL_CPU_BIT] | cpuForce;
                    power    <= '{digReg: regCtrl[REG_DIG_BIT], anaReg: regCtrl[REG_ANA_BIT],
                                  buzz: 1'b0, hibReg: 1'b1, lowClk: 1'b1, fastClk: 1'b1};
                end
                ST_ALT: begin
                    subsysEn <= altTmpl;
                    cpuEn    <= altTmpl[TMPL_CPU_BIT];
                    power    <= '{digReg: regCtrl[REG_DIG_BIT], anaReg: regCtrl[REG_ANA_BIT],
                                  buzz: 1'b0, hibReg: 1'b1, lowClk: 1'b1, fastClk: 1'b1};
                end
                ST_SLEEP: begin
                    subsysEn <= '0;
                    cpuEn    <= 1'b0;
                    power    <= '{digReg: regCtrl[REG_DIG_BIT], anaReg: regCtrl[REG_ANA_BIT],
                                  buzz: 1'b1, hibReg: 1'b1, lowClk: 1'b1, fastClk: 1'b0};
                end
                ST_HIB: begin
                    subsysEn <= '0;
                    cpuEn    <= 1'b0;
                    power    <= '{digReg: 1'b0, anaReg: 1'b0, buzz: 1'b0,
                                  hibReg: 1'b1, lowClk: 1'b0, fastClk: 1'b0};
                end
                ST_RESUME: begin
                    // Regulators out of refresh, enabled per regCtrl; loads stay off until settled
                    subsysEn <= '0;
                    cpuEn    <= 1'b0;
                    power    <= '{digReg: regCtrl[REG_DIG_BIT], anaReg: regCtrl[REG_ANA_BIT],
                                  buzz: 1'b0, hibReg: 1'b1, lowClk: 1'b1, fastClk: 1'b1};
                end
                default: ;
            endcase
        end
    end

    // Read mux
    always_comb begin
        next_prdata = '0;
        unique case (paddr)
            OFS_MODE_REQ: next_prdata[4:0]        = state;
            OFS_ACT_TMPL: next_prdata[TMPL_W-1:0] = actTmpl;
            OFS_ALT_TMPL: next_prdata[TMPL_W-1:0] = altTmpl;
            OFS_REG_CTRL: next_prdata[1:0]        = regCtrl;
            OFS_WAKE_EN:  next_prdata[WAKE_W-1:0] = wakeEn;
            OFS_IRQ_STAT: next_prdata[EVT_W-1:0]  = irqStat;
            OFS_IRQ_MASK: next_prdata[EVT_W-1:0]  = irqMask;
            OFS_STATUS:   next_prdata[6:0]        = {cpuForce, wakeSrc};
            default:      next_prdata             = '0;
        endcase
    end

    // APB answer registers; prdata is taken in setup so it stands in the access cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? next_prdata : '0;
        end
    end

    // Level interrupt, registered
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irqStat | events) & irqMask);
        end
    end
endmodule

// File: core/resume_timer.sv
// Down counter that times the regulator settle on the way out of sleep
module resume_timer
    import pmc_pkg::*;
(
    input  wire  logic clock,       // System clock
    input  wire  logic rst,         // Async reset, active high
    input  wire  logic start,       // Load the count
    output logic       done         // High one cycle when the count expires
);
    localparam logic [CNT_W-1:0] LOAD = CNT_W'(RESUME_CYC - 2);
    logic [CNT_W-1:0] count;        // Remaining cycles
    logic             running;      // Counting

    // Countdown; the two cycles lost in the handshake are taken off the load
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count   <= '0;
            running <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count   <= LOAD;
                running <= 1'b1;
            end else if (running) begin
                if (count == '0) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end else begin
                    count <= count - 1'b1;
                end
            end
        end
    end
endmodule

// File: core/wake_filter.sv
// Wakeup source qualifier: selects sources that may wake the current mode
module wake_filter
    import pmc_pkg::*;
(
    input  wire  logic              clock,      // System clock
    input  wire  logic              rst,        // Async reset, active high
    input  wire  wake_t             sources,    // Raw wakeup sources
    input  wire  logic [WAKE_W-1:0] enables,    // Firmware source enables
    input  wire  logic              inSleep,    // Sleep mode
    input  wire  logic              inHib,      // Hibernate mode
    output logic                    wake        // Registered wake pulse or level
);
    logic [WAKE_W-1:0] raw;                     // Sources as a vector
    logic [WAKE_W-1:0] allowed;                 // Sources valid for the mode

    assign raw = sources;

    // Mode dependent source acceptance
    always_comb begin
        allowed = '0;
        if (inHib) begin
            allowed[WK_PIN] = 1'b1;
        end else if (inSleep) begin
            allowed = '1;
        end
    end

    // Registered so the wake decision is glitch free
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wake <= 1'b0;
        end else begin
            wake <= |(raw & allowed & enables);
        end
    end
endmodule

// File: pkg/pmc_pkg.sv
// Package with register map, field layout, modes and timing for the power mode controller
// What this block does
// - Four modes: active, alternate, sleep, hibernate.
// - Active mode gates subsystems by active template.
// - Alternate active applies its own template.
// - Sleep overrides templates, disables most resources.
// - Sleep keeps timers on low-speed clocks only.
// - Sleep puts both core regulators in refresh.
// - Hibernate retains state, stops every clock.
// - Hibernate wakes only from pin interrupt unit or reset wake.
// - Hibernate: only hibernate regulator stays on.
// - Firmware may disable core regulators, any mode.
// - Regulator enables default on after power-up.
// - Wakeup returns to active, forces core on.
// - Controller starts in active mode after boot.
// - Sleep resume completes within fifteen microseconds.
package pmc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_MODE_REQ  = 8'h00;  // Mode request (write), current mode (read)
    localparam logic [7:0] OFS_ACT_TMPL  = 8'h04;  // Active template
    localparam logic [7:0] OFS_ALT_TMPL  = 8'h08;  // Alternate active template
    localparam logic [7:0] OFS_REG_CTRL  = 8'h0c;  // Internal regulator enables
    localparam logic [7:0] OFS_WAKE_EN   = 8'h10;  // Wakeup source enables
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;  // Sticky event status, write one to clear
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h18;  // Interrupt mask
    localparam logic [7:0] OFS_STATUS    = 8'h1c;  // Live controller status

    // Widths
    localparam int TMPL_W = 16;                    // Power-controllable subsystems
    localparam int WAKE_W = 6;                     // Wakeup sources
    localparam int EVT_W  = 4;                     // Interrupt events
    localparam int MODE_W = 2;                     // Mode request code width

    // Template bit used for the processor core
    localparam int TMPL_CPU_BIT = 0;

    // Reset values
    localparam logic [TMPL_W-1:0] ACT_TMPL_RST = 16'hffff;
    localparam logic [TMPL_W-1:0] ALT_TMPL_RST = 16'hfffe;
    localparam logic [1:0]        REG_CTRL_RST = 2'h3;
    localparam logic [WAKE_W-1:0] WAKE_EN_RST  = 6'h3f;

    // Regulator control field positions
    localparam int REG_DIG_BIT = 0;
    localparam int REG_ANA_BIT = 1;

    // Wakeup source bit positions
    localparam int WK_CMP  = 0;                    // Comparator
    localparam int WK_PIN  = 1;                    // pin_interrupt_unit
    localparam int WK_I2C  = 2;                    // I2C address match
    localparam int WK_RTC  = 3;                    // Real-time clock
    localparam int WK_PWC  = 4;                    // periodic_wake_counter
    localparam int WK_SDD  = 5;                    // supply_drop_detector

    // Event bit positions
    localparam int EV_SLEEP_IN  = 0;
    localparam int EV_HIB_IN    = 1;
    localparam int EV_WAKE      = 2;
    localparam int EV_BAD_REQ   = 3;

    // Mode request codes
    localparam logic [MODE_W-1:0] REQ_ACTIVE = 2'h0;
    localparam logic [MODE_W-1:0] REQ_ALT    = 2'h1;
    localparam logic [MODE_W-1:0] REQ_SLEEP  = 2'h2;
    localparam logic [MODE_W-1:0] REQ_HIB    = 2'h3;

    // Timing
    localparam int CLK_MHZ       = 100;
    localparam int RESUME_NS     = 15000;      // Longest sleep resume
    localparam int RESUME_CYC    = (RESUME_NS * CLK_MHZ) / 1000;
    localparam int CNT_W         = 11;

    // One-hot global mode states
    typedef enum logic [4:0] {
        ST_ACTIVE = 5'b00001,
        ST_ALT    = 5'b00010,
        ST_SLEEP  = 5'b00100,
        ST_HIB    = 5'b01000,
        ST_RESUME = 5'b10000
    } mode_t;

    // Wakeup sources bundled
    typedef struct packed {
        logic supplyDrop;
        logic periodicWake;
        logic rtc;
        logic i2c;
        logic pinIrq;
        logic comparator;
    } wake_t;

    // Regulator and clock controls bundled
    typedef struct packed {
        logic digReg;       // Digital core regulator on
        logic anaReg;       // Analog core regulator on
        logic buzz;         // Core regulators in periodic refresh
        logic hibReg;       // Hibernate regulator on
        logic lowClk;       // Low-speed and watch crystal clocks run
        logic fastClk;      // High-speed clocks run
    } power_t;

endpackage

// File: verif/pmc_checker.sv
// Port-level checker for the power mode controller
module pmc_checker
    import pmc_pkg::*;
(
    input wire logic              clock,     // System clock
    input wire logic              rst,       // Async reset
    input wire logic              psel,      // APB select
    input wire logic              penable,   // APB access phase
    input wire logic              pwrite,    // APB direction
    input wire logic [7:0]        paddr,     // APB address
    input wire logic [31:0]       pwdata,    // APB write data
    input wire logic [31:0]       prdata,    // APB read data
    input wire logic              pready,    // APB ready
    input wire logic              pslverr,   // APB error
    input wire wake_t             wakeSrc,   // Wakeup sources
    input wire logic              resetWake, // Reset-type wake
    input wire logic [TMPL_W-1:0] subsysEn,  // Subsystem enables
    input wire logic              cpuEn,     // Core enable
    input wire power_t            power,     // Power controls
    input wire logic [4:0]        modeNow,   // One-hot mode
    input wire logic              irq        // Interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RESUME_MIN = RESUME_CYC - 10; // Fewest resume cycles: regulators must settle
    localparam int RESUME_MAX = RESUME_CYC + 10; // Most resume cycles allowed
    logic        modeWr;                 // Completing write to the mode register
    logic [11:0] resumeCnt;              // Cycles spent in resume so far
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // Only a completed bus write may move the mode away from active
    assign modeWr = psel && penable && pwrite && (paddr == OFS_MODE_REQ);
    // Count resume cycles; a delay range this long would crawl in the tools
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            resumeCnt <= '0;
        end else if (modeNow == ST_RESUME) begin
            resumeCnt <= resumeCnt + 12'h1;
        end else begin
            resumeCnt <= '0;
        end
    end
    // Resume holds a while, then active with the core forced on
    sequence resumeHold;
        (modeNow == ST_RESUME) [*8];
    endsequence
    sequence backActive;
        (modeNow == ST_ACTIVE) && cpuEn;
    endsequence
    onehot_mode_a: assert property ($onehot(modeNow))
        else $error("mode is not one-hot");
    sleep_power_a: assert property ((modeNow == ST_SLEEP) |->
        subsysEn == '0 && !cpuEn && power.buzz) else $error("sleep power wrong");
    sleep_clock_a: assert property ((modeNow == ST_SLEEP) |->
        power.lowClk && !power.fastClk) else $error("sleep clocks wrong");
    hib_power_a: assert property ((modeNow == ST_HIB) |-> power.hibReg && !power.digReg
        && !power.anaReg && !power.lowClk && !power.fastClk && subsysEn == '0)
        else $error("hibernate power wrong");
    hib_wake_a: assert property ((modeNow == ST_HIB) ##1 (modeNow == ST_RESUME) |->
        $past(wakeSrc.pinIrq, 2) || $past(wakeSrc.pinIrq, 3) || $past(resetWake, 2)
        || $past(resetWake, 3)) else $error("hibernate left without pin wake");
    resume_time_a: assert property ($rose(modeNow == ST_RESUME) |-> resumeHold)
        else $error("resume too short");
    resume_limit_a: assert property ((modeNow == ST_RESUME) |-> resumeCnt < RESUME_MAX)
        else $error("resume too long");
    resume_exit_a: assert property ((modeNow == ST_RESUME) ##1 (modeNow != ST_RESUME) |->
        backActive && resumeCnt >= RESUME_MIN) else $error("resume left wrongly");
    low_entry_a: assert property ((modeNow == ST_ACTIVE) ##1
        (modeNow inside {ST_SLEEP, ST_HIB, ST_ALT}) |-> $past(modeWr, 2) || $past(modeWr, 3))
        else $error("mode left active without request");
    ready_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_idle_a: assert property (!(psel && !penable) |=> !pready)
        else $error("ready without setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule

bind power_mode_controller pmc_checker chk_u (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wakeSrc(wakeSrc), .resetWake(resetWake),
    .subsysEn(subsysEn), .cpuEn(cpuEn), .power(power), .modeNow(modeNow), .irq(irq));

// File: verif/tb.sv
// Self-checking bench for the power mode controller
module tb;
    import pmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clock = 0;      // System clock
    logic              rst = 1;        // Reset
    logic              psel = 0;       // Bus controls
    logic              penable = 0;
    logic              pwrite = 0;
    logic              resetWake = 0;  // Reset-type wake
    logic [7:0]        paddr = 0;
    logic [31:0]       pwdata = 0;
    logic [31:0]       prdata;
    logic              pready, pslverr, cpuEn, irq;
    wake_t             wakeSrc = '0;   // Wake sources
    logic [TMPL_W-1:0] subsysEn;
    power_t            power;
    logic [4:0]        modeNow;
    logic [32:0]       expQ[$];        // Expected read notes
    int                n_fail = 0;
    int                n_checks = 0;
    logic [15:0]       t, a;           // Random templates
    // Free-running clock
    always #5 clock = ~clock;
    power_mode_controller dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wakeSrc(wakeSrc), .resetWake(resetWake), .subsysEn(subsysEn),
        .cpuEn(cpuEn), .power(power), .modeNow(modeNow), .irq(irq));
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One transfer; an idle edge first so no signal is assigned twice in a step
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        if (!w) expQ.push_back(e);
        @(posedge clock);
        penable <= 1;
        // Ready is judged at the rising edge; release only after it is seen high
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) n_fail++;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d, '0);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [32:0] e);
        apb(1'b0, ad, '0, e);
    endtask
    // Bounded wait for a mode; the bound doubles as the timing limit
    task automatic wait_mode(input logic [4:0] m, input int lim);
        int n;
        n = 0;
        while (modeNow !== m && n < lim) begin
            @(negedge clock);
            n++;
        end
        check(modeNow, m);
    endtask
    task automatic sleep_on;
        wr(OFS_MODE_REQ, 32'(REQ_SLEEP));
        wait_mode(ST_SLEEP, 20);
    endtask
    // Read watcher: oldest note against what the bus returns
    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
            check({pslverr, prdata}, expQ.pop_front());
        end
    end
    // Watchdog sized well past the eight resume waits
    initial begin
        repeat (40000) @(posedge clock);
        n_fail++;
        close_out();
    end
    initial begin
        void'($urandom(32'h6114));
        repeat (3) @(posedge clock);
        rst <= 0;
        check(modeNow, ST_ACTIVE);
        rd(OFS_MODE_REQ, 33'h1);
        rd(OFS_REG_CTRL, 33'h3);
        rd(OFS_ACT_TMPL, 33'hffff);
        rd(OFS_ALT_TMPL, 33'hfffe);
        rd(OFS_WAKE_EN, 33'h3f);
        rd(OFS_IRQ_MASK, 33'h0);
        rd(8'h20, 33'h1_0000_0000);
        $display("test reset values done");
        t = 16'($urandom);
        a = 16'($urandom);
        wr(OFS_ACT_TMPL, {16'h0, t});
        repeat (2) @(negedge clock);
        check({subsysEn, cpuEn}, {t, t[TMPL_CPU_BIT]});
        wr(OFS_ALT_TMPL, {16'h0, a});
        wr(OFS_MODE_REQ, 32'(REQ_ALT));
        wait_mode(ST_ALT, 20);
        check(subsysEn, a);
        wr(OFS_MODE_REQ, 32'(REQ_ACTIVE));
        wait_mode(ST_ACTIVE, 20);
        check(subsysEn, t);
        $display("test templates done");
        wr(OFS_REG_CTRL, 32'h0);
        repeat (2) @(negedge clock);
        check({power.digReg, power.anaReg}, 2'b00);
        wr(OFS_REG_CTRL, 32'h3);
        repeat (2) @(negedge clock);
        check({power.digReg, power.anaReg}, 2'b11);
        $display("test regulators done");
        wr(OFS_ACT_TMPL, 32'hfffe);
        repeat (2) @(negedge clock);
        check(cpuEn, 1'b0);
        wr(OFS_IRQ_MASK, 32'h5);
        sleep_on();
        check({subsysEn, cpuEn, power.buzz, power.lowClk, power.fastClk}, 20'h6);
        repeat (2) @(negedge clock);
        check(irq, 1'b1);
        wr(OFS_IRQ_MASK, 32'h0);
        repeat (2) @(negedge clock);
        check(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h5);
        wr(OFS_MODE_REQ, 32'(REQ_ACTIVE));
        repeat (4) @(negedge clock);
        check(modeNow, ST_SLEEP);
        rd(OFS_IRQ_STAT, 33'h9);
        wr(OFS_WAKE_EN, 32'h3e);
        @(posedge clock);
        wakeSrc <= wake_t'(6'h1 << WK_CMP);
        repeat (20) @(negedge clock);
        check(modeNow, ST_SLEEP);
        @(posedge clock);
        wakeSrc <= '0;
        wr(OFS_WAKE_EN, 32'h3f);
        $display("test sleep entry done");
        // Each sleep source in turn must bring the core back within the resume time
        for (int i = 0; i < WAKE_W; i++) begin
            if (modeNow !== ST_SLEEP) sleep_on();
            @(posedge clock);
            wakeSrc <= wake_t'(6'h1 << i);
            wait_mode(ST_ACTIVE, RESUME_CYC + 10);
            check(cpuEn, 1'b1);
            @(posedge clock);
            wakeSrc <= '0;
        end
        check(irq, 1'b1);
        wr(OFS_IRQ_STAT, 32'hf);
        repeat (2) @(negedge clock);
        check(irq, 1'b0);
        $display("test sleep wakes done");
        wr(OFS_MODE_REQ, 32'(REQ_HIB));
        wait_mode(ST_HIB, 20);
        check({subsysEn, power.digReg, power.anaReg, power.hibReg, power.lowClk,
               power.fastClk}, 21'h4);
        @(posedge clock);
        wakeSrc <= wake_t'(6'($urandom) & 6'h3d | 6'h1);
        repeat (20) @(negedge clock);
        check(modeNow, ST_HIB);
        @(posedge clock);
        wakeSrc <= wake_t'(6'h1 << WK_PIN);
        wait_mode(ST_ACTIVE, RESUME_CYC + 20);
        @(posedge clock);
        wakeSrc <= '0;
        wr(OFS_MODE_REQ, 32'(REQ_HIB));
        wait_mode(ST_HIB, 20);
        @(posedge clock);
        resetWake <= 1;
        wait_mode(ST_ACTIVE, RESUME_CYC + 20);
        @(posedge clock);
        resetWake <= 0;
        $display("test hibernate done");
        close_out();
    end
endmodule
